/* File: design/fpu_clip_clear_compare.sv */
// Instruction sequencer for reverse clipping, register clear and compare.
// Assumes the host issues one command at a time and supplies operand words.
`timescale 1ns/1ps
`default_nettype none
module fpu_clip_clear_compare
  import fpu_ops_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire op_t cmd_op,
  input wire fmt_t cmd_fmt,
  input wire logic [4:0] cmd_src1,
  input wire logic [4:0] cmd_src2,
  input wire logic [4:0] cmd_dest,
  input wire logic word_valid,
  output logic word_ready,
  input wire logic [31:0] word_data,
  output logic done,
  output logic flag_n,
  output logic flag_z,
  output logic flag_v,
  input wire logic [4:0] rd_sel,
  output logic [63:0] rd_data
);
  typedef enum logic [2:0] {
    st_idle, st_clip_start, st_clip_div, st_clip_interp, st_load, st_cmp_eval
  } state_t;

  state_t state_q, state_d;
  op_t op_q, op_d;
  fmt_t fmt_q, fmt_d;
  logic [4:0] src1_q, src1_d, src2_q, src2_d;
  logic [1:0] plane_q, plane_d, k_q, k_d;
  logic [2:0] word_q, word_d;
  logic [63:0] a_q [REG_FILE_DEPTH];
  logic [63:0] a_d [REG_FILE_DEPTH];
  logic [63:0] b_q [REG_FILE_DEPTH];
  logic [63:0] b_d [REG_FILE_DEPTH];
  logic [63:0] c_q, c_d, ct_q, ct_d, rd_q, rd_d;
  logic n_q, n_d, z_q, z_d, v_q, v_d, done_q, done_d;
  logic wr_en;
  logic [4:0] wr_idx;
  logic [63:0] wr_val, wr_old;
  logic [1:0] wpo;
  logic signed [31:0] p1p, p2p, clip_a, clip_b, p1k, p2k, diff, res;
  logic signed [63:0] prod;
  logic signed [64:0] cmp_diff;

  fpu_div_if dv ();

  fpu_divider #(.STEPS(DIV_STEPS)) u_div (
    .sys_clk(sys_clk),
    .reset(reset),
    .clk_en(clk_en),
    .dv(dv)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic signed [31:0] lo(input logic [63:0] v);
    lo = signed'(v[31:0]);
  endfunction

  function automatic logic [63:0] sx(input logic signed [31:0] v);
    sx = {{32{v[31]}}, v};
  endfunction

  // Unmapped indices read as zero
  function automatic logic [63:0] reg_value(input logic [4:0] idx);
    reg_value = 64'h0000000000000000;
    if (idx == IDX_CONST_C) reg_value = c_q;
    else if (idx == IDX_TEMP) reg_value = ct_q;
    else if (idx[3:0] < FILE_LIMIT) reg_value = idx[4] ? b_q[idx[3:0]] : a_q[idx[3:0]];
  endfunction

  // Sign-magnitude floats map onto an ordered integer so one subtractor serves all
  function automatic logic signed [63:0] cmp_key(input logic [63:0] v, input fmt_t f);
    cmp_key = 64'sh0;
    unique case (f)
      fmt_integer: cmp_key = signed'(sx(lo(v)));
      fmt_single: cmp_key = v[31] ? -signed'({33'h0, v[30:0]}) : signed'({33'h0, v[30:0]});
      fmt_double: cmp_key = v[63] ? -signed'({1'b0, v[62:0]}) : signed'({1'b0, v[62:0]});
      default: cmp_key = 64'sh0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  // Plane coordinates and the a/b terms of the clip
  assign p1p = lo(a_q[plane_q]);
  assign p2p = lo(b_q[plane_q]);
  assign clip_a = p2p[31] ? lo(b_q[LAST_COORD]) + p2p : lo(b_q[LAST_COORD]) - p2p;
  assign clip_b = p2p[31] ? lo(a_q[LAST_COORD]) + p1p : lo(a_q[LAST_COORD]) - p1p;
  // Interpolation of coordinate k, t held as Q16.16 in C
  assign p1k = lo(a_q[k_q]);
  assign p2k = lo(b_q[k_q]);
  assign diff = p1k - p2k;
  assign prod = 64'(diff) * 64'(lo(c_q));
  assign res = p2k + 32'(prod >>> T_FRAC_BITS);
  // Index-map reads in a process, so that file writes retrigger them
  always_comb begin
    wr_old = reg_value(wr_idx);
    cmp_diff = 65'(cmp_key(reg_value(src1_q), fmt_q))
             - 65'(cmp_key(reg_value(src2_q), fmt_q));
  end
  // Host-register form never carries double words
  assign wpo = (fmt_q == fmt_double && op_q != cmp_host_load_op) ? WORDS_WIDE : WORDS_NARROW;

  assign dv.start = (state_q == st_clip_start);
  assign dv.dividend = 64'(sx(clip_a)) <<< T_FRAC_BITS;
  assign dv.divisor = clip_a - clip_b;

  // ----------------------------------------------------------------
  // Sequencer and register files: next values
  // ----------------------------------------------------------------
  always_comb begin
    {state_d, op_d, fmt_d, src1_d, src2_d} = {state_q, op_q, fmt_q, src1_q, src2_q};
    {plane_d, k_d, word_d} = {plane_q, k_q, word_q};
    {c_d, ct_d, n_d, z_d, v_d} = {c_q, ct_q, n_q, z_q, v_q};
    a_d = a_q;
    b_d = b_q;
    done_d = 1'b0;
    wr_en = 1'b0;
    wr_idx = src1_q;
    wr_val = 64'h0000000000000000;
    rd_d = reg_value(rd_sel);
    unique case (state_q)
      st_idle: begin
        if (cmd_valid) begin
          {op_d, fmt_d, src1_d, src2_d} = {cmd_op, cmd_fmt, cmd_src1, cmd_src2};
          plane_d = (cmd_op == reverse_clip_y_op) ? PLANE_Y : PLANE_Z;
          word_d = 3'h0;
          unique case (cmd_op)
            reverse_clip_y_op, reverse_clip_z_op: state_d = st_clip_start;
            register_zero_op: begin
              // Zero has the all-zero pattern in every format
              wr_en = 1'b1;
              wr_idx = cmd_dest;
              z_d = 1'b1;
              n_d = 1'b0;
              done_d = 1'b1;
            end
            subtract_compare_op: state_d = st_cmp_eval;
            cmp_host_load_op, cmp_mem_postinc_op, cmp_mem_predec_op: state_d = st_load;
            default: state_d = st_idle;
          endcase
        end
      end
      st_clip_start: begin
        a_d[SCRATCH_LO] = sx(clip_a);
        b_d[SCRATCH_LO] = sx(clip_a - clip_b);
        state_d = st_clip_div;
      end
      st_clip_div: begin
        if (dv.done) begin
          c_d = sx(dv.quotient);
          v_d = dv.div_zero;
          k_d = 2'h0;
          state_d = st_clip_interp;
        end
      end
      st_clip_interp: begin
        // First endpoint is lost coordinate by coordinate
        a_d[k_q] = sx(res);
        ct_d = 64'(prod);
        if (k_q == 2'h0) b_d[SCRATCH_HI] = sx(diff);
        else if (k_q == PLANE_Z) a_d[SCRATCH_LO] = sx(diff);
        else a_d[SCRATCH_HI] = sx(diff);
        k_d = k_q + 2'h1;
        if (k_q == LAST_COORD) begin
          state_d = st_idle;
          done_d = 1'b1;
        end
      end
      st_load: begin
        // Fixed count: two operands of one or two words, low word first
        if (word_valid) begin
          wr_en = 1'b1;
          wr_idx = (word_q >= 3'(wpo)) ? src2_q : src1_q;
          if (wpo == WORDS_NARROW) wr_val = {32'h00000000, word_data};
          else if (word_q[0]) wr_val = {word_data, wr_old[31:0]};
          else wr_val = {wr_old[63:32], word_data};
          word_d = word_q + 3'h1;
          if (word_q == 3'({wpo, 1'b0} - 3'h1)) state_d = st_cmp_eval;
        end
      end
      st_cmp_eval: begin
        // Difference goes to the flags only
        n_d = cmp_diff[64];
        z_d = (cmp_diff == 65'sh0);
        v_d = 1'b0;
        done_d = 1'b1;
        state_d = st_idle;
      end
      default: state_d = st_idle;
    endcase
    // Single write port shared by clear and operand loads
    if (wr_en) begin
      if (wr_idx == IDX_CONST_C) c_d = wr_val;
      else if (wr_idx == IDX_TEMP) ct_d = wr_val;
      else if (wr_idx[3:0] < FILE_LIMIT && wr_idx[4]) b_d[wr_idx[3:0]] = wr_val;
      else if (wr_idx[3:0] < FILE_LIMIT) a_d[wr_idx[3:0]] = wr_val;
    end
  end

  // State registers, frozen while the clock enable is low
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_q <= st_idle;
      op_q <= subtract_compare_op;
      fmt_q <= fmt_integer;
      {src1_q, src2_q, plane_q, k_q, word_q} <= '0;
      {c_q, ct_q, rd_q} <= '0;
      {n_q, z_q, v_q, done_q} <= 4'h0;
      for (int i = 0; i < REG_FILE_DEPTH; i++) begin
        a_q[i] <= 64'h0000000000000000;
        b_q[i] <= 64'h0000000000000000;
      end
    end else if (clk_en) begin
      {state_q, op_q, fmt_q, src1_q, src2_q} <= {state_d, op_d, fmt_d, src1_d, src2_d};
      {plane_q, k_q, word_q} <= {plane_d, k_d, word_d};
      {c_q, ct_q, rd_q} <= {c_d, ct_d, rd_d};
      {n_q, z_q, v_q, done_q} <= {n_d, z_d, v_d, done_d};
      a_q <= a_d;
      b_q <= b_d;
    end
  end

  // Handshakes are combinational; they also fall with the clock enable
  assign cmd_ready = (state_q == st_idle) && clk_en;
  assign word_ready = (state_q == st_load) && clk_en;
  assign {done, flag_n, flag_z, flag_v, rd_data} = {done_q, n_q, z_q, v_q, rd_q};

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_clip_t_stored: assert property (@(posedge sys_clk) disable iff (reset || !clk_en)
    state_q == st_clip_div && dv.done |=> lo(c_q) == $past(dv.quotient))
    else $error("clip factor not held in C");
  a_clip_x_result: assert property (@(posedge sys_clk) disable iff (reset || !clk_en)
    state_q == st_clip_interp && k_q == 2'h0 |=>
      lo(a_q[0]) == $past(p2k) + 32'($past(prod) >>> T_FRAC_BITS))
    else $error("clipped X wrong");
  a_clip_walk_len: assert property (@(posedge sys_clk) disable iff (reset || !clk_en)
    state_q == st_clip_interp && k_q == 2'h0 |->
      ##3 (state_q == st_clip_interp && k_q == LAST_COORD) ##1 done)
    else $error("clip overwrite sequence broken");
  a_clip_b_kept: assert property (@(posedge sys_clk) disable iff (reset || !clk_en)
    state_q == st_clip_interp |=> $stable({b_q[0], b_q[1], b_q[2], b_q[3]}))
    else $error("second endpoint disturbed");
  a_clip_divisor: assert property (@(posedge sys_clk) disable iff (reset || !clk_en)
    state_q == st_clip_start |-> dv.start && dv.divisor == lo(b_q[LAST_COORD])
      - lo(a_q[LAST_COORD]) + (p2p[31] ? p2p - p1p : p1p - p2p))
    else $error("divisor not a-b");
  a_clear_sets_z: assert property (@(posedge sys_clk) disable iff (reset || !clk_en)
    cmd_valid && cmd_ready && cmd_op == register_zero_op |=> done && flag_z && !flag_n)
    else $error("clear did not set zero flag");
  a_cmp_flags_set: assert property (@(posedge sys_clk) disable iff (reset || !clk_en)
    state_q == st_cmp_eval |=> done && flag_n == $past(cmp_diff[64])
      && flag_z == ($past(cmp_diff) == 65'sh0) && $stable(c_q) && $stable(ct_q))
    else $error("compare flags wrong");
  a_load_word_cnt: assert property (@(posedge sys_clk) disable iff (reset || !clk_en)
    state_q == st_load && word_valid && word_q == 3'({wpo, 1'b0} - 3'h1)
      |=> state_q == st_cmp_eval ##1 done)
    else $error("load count wrong");
  c_clip_done: cover property (@(posedge sys_clk) disable iff (reset)
    state_q == st_clip_interp && k_q == LAST_COORD ##1 done);
  c_cmp_mem_wide: cover property (@(posedge sys_clk) disable iff (reset)
    state_q == st_load && fmt_q == fmt_double && word_q == 3'h3 && word_valid);
  c_cmp_host: cover property (@(posedge sys_clk) disable iff (reset)
    state_q == st_cmp_eval && op_q == cmp_host_load_op);
endmodule // fpu_clip_clear_compare
`default_nettype wire

/* File: design/fpu_ops_pkg.sv */
// Shared constants and types for the coprocessor clip, clear and compare block.
// Assumes one 100 MHz clock domain; no software-visible registers.
`default_nettype none
package fpu_ops_pkg;

  // ----------------------------------------------------------------
  // Operations and operand formats
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    reverse_clip_y_op,
    reverse_clip_z_op,
    register_zero_op,
    subtract_compare_op,
    cmp_host_load_op,
    cmp_mem_postinc_op,
    cmp_mem_predec_op
  } op_t;

  typedef enum logic [1:0] {
    fmt_integer,
    fmt_single,
    fmt_double
  } fmt_t;

  // ----------------------------------------------------------------
  // Register indices: file A 0..9, file B 16..25, C and temp at top
  // ----------------------------------------------------------------
  localparam int unsigned REG_FILE_DEPTH = 10;
  localparam logic [4:0] IDX_CONST_C = 5'h1E;
  localparam logic [4:0] IDX_TEMP = 5'h1F;
  localparam logic [3:0] FILE_LIMIT = 4'hA;
  localparam logic [1:0] PLANE_Y = 2'h1;
  localparam logic [1:0] PLANE_Z = 2'h2;
  localparam logic [1:0] LAST_COORD = 2'h3;
  localparam int unsigned SCRATCH_LO = 8;
  localparam int unsigned SCRATCH_HI = 9;

  // ----------------------------------------------------------------
  // Arithmetic and transfer constants
  // ----------------------------------------------------------------
  localparam int unsigned T_FRAC_BITS = 16;
  localparam int unsigned DIV_STEPS = 48;
  localparam logic [31:0] DIV_ZERO_QUOTIENT = 32'h7FFFFFFF;
  localparam logic [1:0] WORDS_NARROW = 2'h1;
  localparam logic [1:0] WORDS_WIDE = 2'h2;

endpackage
`default_nettype wire

/* File: design/fpu_div_if.sv */
// Handshake between the instruction sequencer and its divider.
// Assumes both ends share sys_clk; start is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
interface fpu_div_if;
  logic start;
  logic signed [63:0] dividend;
  logic signed [31:0] divisor;
  logic done;
  logic div_zero;
  logic signed [31:0] quotient;

  modport requester (output start, output dividend, output divisor,
                     input done, input div_zero, input quotient);
  modport provider (input start, input dividend, input divisor,
                    output done, output div_zero, output quotient);
endinterface
`default_nettype wire

/* File: design/fpu_divider.sv */
// Sequential signed divider, one quotient bit per enabled clock.
// Assumes operands are held by the requester only on the start cycle.
`timescale 1ns/1ps
`default_nettype none
module fpu_divider
  import fpu_ops_pkg::*;
#(
  parameter int unsigned STEPS = DIV_STEPS
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  fpu_div_if.provider dv
);
  logic [47:0] quo_q, quo_d;
  logic [32:0] rem_q, rem_d;
  logic [31:0] dvs_q, dvs_d, res_q, res_d;
  logic [5:0] cnt_q, cnt_d;
  logic neg_q, neg_d, busy_q, busy_d, done_q, done_d, dz_q, dz_d;
  logic [63:0] dd_mag;
  logic [32:0] rem_sh;

  // ----------------------------------------------------------------
  // Restoring division on magnitudes, sign applied at the end
  // ----------------------------------------------------------------
  always_comb begin
    {quo_d, rem_d, dvs_d, res_d, cnt_d} = {quo_q, rem_q, dvs_q, res_q, cnt_q};
    {neg_d, busy_d, dz_d} = {neg_q, busy_q, dz_q};
    done_d = 1'b0;
    dd_mag = dv.dividend[63] ? 64'(-dv.dividend) : 64'(dv.dividend);
    rem_sh = {rem_q[31:0], quo_q[47]};
    if (dv.start) begin
      dvs_d = dv.divisor[31] ? 32'(-dv.divisor) : 32'(dv.divisor);
      quo_d = dd_mag[47:0];
      rem_d = 33'h000000000;
      neg_d = dv.dividend[63] ^ dv.divisor[31];
      cnt_d = 6'h00;
      dz_d = (dv.divisor == 32'sh00000000);
      busy_d = !dz_d;
      // Zero divisor answers at once with a saturated quotient
      if (dz_d) begin
        done_d = 1'b1;
        res_d = DIV_ZERO_QUOTIENT;
      end
    end else if (busy_q) begin
      if (rem_sh >= {1'b0, dvs_q}) begin
        rem_d = rem_sh - {1'b0, dvs_q};
        quo_d = {quo_q[46:0], 1'b1};
      end else begin
        rem_d = rem_sh;
        quo_d = {quo_q[46:0], 1'b0};
      end
      cnt_d = cnt_q + 6'h01;
      if (cnt_q == 6'(STEPS - 1)) begin
        busy_d = 1'b0;
        done_d = 1'b1;
        res_d = neg_q ? 32'(-quo_d[31:0]) : quo_d[31:0];
      end
    end
  end

  // State registers, frozen while the clock enable is low
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      {quo_q, rem_q, dvs_q, res_q, cnt_q} <= '0;
      {neg_q, busy_q, done_q, dz_q} <= 4'h0;
    end else if (clk_en) begin
      {quo_q, rem_q, dvs_q, res_q, cnt_q} <= {quo_d, rem_d, dvs_d, res_d, cnt_d};
      {neg_q, busy_q, done_q, dz_q} <= {neg_d, busy_d, done_d, dz_d};
    end
  end

  assign dv.done = done_q;
  assign dv.div_zero = dz_q;
  assign dv.quotient = res_q;
endmodule // fpu_divider
`default_nettype wire

/* File: testbench/host_model.sv */
// Host model: hands operand words to the block from a small memory.
// Assumes the bench presets mem and pulses go for one cycle.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic go,
  input wire logic predec,
  input wire logic [2:0] nwords,
  input wire logic [1:0] gap,
  input wire logic [15:0] ptr_init,
  input wire logic word_ready,
  output logic word_valid,
  output logic [31:0] word_data,
  output logic [15:0] ptr,
  output logic [2:0] left
);
  logic [31:0] mem [0:31];
  logic [31:0] last;
  logic [1:0] wcnt;

  // ----------------------------------------------------------------
  // Word sequencing
  // ----------------------------------------------------------------
  // Fixed word count, pointer stepped by 32 per word
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      left <= 3'h0;
      wcnt <= 2'h0;
      ptr <= 16'h0000;
      last <= 32'h0000_0000;
    end else if (go) begin
      left <= nwords;
      wcnt <= gap;
      ptr <= predec ? ptr_init - 16'h0020 : ptr_init;
    end else if (left != 3'h0) begin
      if (wcnt != 2'h0) begin
        wcnt <= wcnt - 2'h1;
      end else if (word_ready) begin
        left <= left - 3'h1;
        wcnt <= gap;
        last <= word_data;
        if (!predec) ptr <= ptr + 16'h0020;
        else if (left > 3'h1) ptr <= ptr - 16'h0020;
      end
    end
  end

  // Idle data line shows the inverse, so no stale word looks valid
  assign word_valid = (left != 3'h0) && (wcnt == 2'h0);
  assign word_data = word_valid ? mem[ptr[9:5]] : ~last;
endmodule // host_model
`default_nettype wire

/* File: testbench/fpu_clip_clear_compare_tb.sv */
// Self-checking bench for the clip, clear and compare sequencer.
// Assumes host_model feeds the word port; registers seen via rd_sel.
`timescale 1ns/1ps
`default_nettype none
module fpu_clip_clear_compare_tb
  import fpu_ops_pkg::*;
;
  logic sys_clk, reset, clk_en, cmd_valid, cmd_ready, done;
  logic word_valid, word_ready, flag_n, flag_z, flag_v, go, predec;
  op_t cmd_op;
  fmt_t cmd_fmt;
  logic [4:0] cmd_src1, cmd_src2, cmd_dest, rd_sel;
  logic [31:0] word_data;
  logic [63:0] rd_data, v;
  logic [2:0] nwords, left;
  logic [1:0] gap;
  logic [15:0] ptr_init, ptr;
  int mismatches, n_compared;
  int cycles = 0;

  fpu_clip_clear_compare u_dut (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_fmt(cmd_fmt),
    .cmd_src1(cmd_src1), .cmd_src2(cmd_src2), .cmd_dest(cmd_dest),
    .word_valid(word_valid), .word_ready(word_ready), .word_data(word_data),
    .done(done), .flag_n(flag_n), .flag_z(flag_z), .flag_v(flag_v),
    .rd_sel(rd_sel), .rd_data(rd_data));
  host_model u_host (.sys_clk(sys_clk), .reset(reset), .go(go), .predec(predec),
    .nwords(nwords), .gap(gap), .ptr_init(ptr_init), .word_ready(word_ready),
    .word_valid(word_valid), .word_data(word_data), .ptr(ptr), .left(left));

  // ----------------------------------------------------------------
  // Clock, watchdog and reporting
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Runaway guard, well above the few hundred cycles used
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end

  task automatic results();
    $display("mismatches %0d compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // Port tasks, all entered and left just after a rising edge
  // ----------------------------------------------------------------
  // Hold the command until ready is seen, sampled mid-cycle
  task automatic issue(input op_t op, input fmt_t f, input logic [4:0] s1,
                       input logic [4:0] s2);
    logic ok;
    cmd_op <= op;
    cmd_fmt <= f;
    cmd_src1 <= s1;
    cmd_src2 <= s2;
    cmd_dest <= s1;
    cmd_valid <= 1'b1;
    repeat (100) begin
      @(negedge sys_clk);
      ok = cmd_ready;
      @(posedge sys_clk);
      if (ok) break;
    end
  endtask

  task automatic wait_done(output int n);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (done !== 1'b1 && n < 200);
    chk(done, 1'b1);
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [4:0] sel, output logic [63:0] val);
    rd_sel <= sel;
    @(posedge sys_clk);
    @(negedge sys_clk);
    val = rd_data;
    @(posedge sys_clk);
  endtask

  task automatic chk_flags(input logic n, input logic z);
    @(negedge sys_clk);
    chk(flag_n, n);
    chk(flag_z, z);
    chk(flag_v, 1'b0);
    @(posedge sys_clk);
  endtask

  // Start the host, then a loading command; ptr_init and gap set before
  task automatic xfer(input op_t op, input fmt_t f, input logic pd, input logic [2:0] n,
                      input logic [4:0] s1, input logic [4:0] s2);
    int c;
    predec <= pd;
    nwords <= n;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    issue(op, f, s1, s2);
    wait_done(c);
    chk(left, 3'h0);
  endtask

  // Two host registers into an A and a B entry; never double
  task automatic hload(input logic [4:0] s1, input logic [4:0] s2, input logic [31:0] va,
                       input logic [31:0] vb, input fmt_t f);
    u_host.mem[24] = va;
    u_host.mem[25] = vb;
    ptr_init <= 16'h0300;
    gap <= 2'h0;
    xfer(cmp_host_load_op, f, 1'b0, 3'h2, s1, s2);
  endtask

  task automatic regcmp(input logic [4:0] s1, input logic [4:0] s2, input logic n,
                        input logic z);
    int c;
    issue(subtract_compare_op, fmt_integer, s1, s2);
    wait_done(c);
    chk_flags(n, z);
  endtask

  // ----------------------------------------------------------------
  // Reverse clip, expectation in Q16.16 from the stored endpoints
  // ----------------------------------------------------------------
  task automatic do_clip(input op_t op, input int k, input int p1[4], input int p2[4]);
    longint a, b, t;
    logic [31:0] t32, e;
    int c;
    for (int i = 0; i < 4; i++) hload(5'(i), 5'(16 + i), p1[i], p2[i], fmt_integer);
    a = (p2[k] < 0) ? longint'(p2[3]) + p2[k] : longint'(p2[3]) - p2[k];
    b = (p2[k] < 0) ? longint'(p1[3]) + p1[k] : longint'(p1[3]) - p1[k];
    t = (a == b) ? 64'sh7FFF_FFFF : (a <<< 16) / (a - b);
    t32 = t[31:0];
    issue(op, fmt_integer, 5'h00, 5'h10);
    wait_done(c);
    chk(c < 20, a == b);
    @(negedge sys_clk);
    chk(flag_v, a == b);
    @(posedge sys_clk);
    rd(IDX_CONST_C, v);
    chk(v, {{32{t32[31]}}, t32});
    for (int i = 0; (a != b) && i < 4; i++) begin
      rd(5'(i), v);
      e = 32'(p2[i] + ((longint'(p1[i] - p2[i]) * t) >>> 16));
      chk(v[31:0], e);
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int c;
    {reset, clk_en, cmd_valid, go, predec} = 5'b11000;
    {cmd_src1, cmd_src2, cmd_dest, rd_sel} = 20'h00000;
    cmd_op = register_zero_op;
    cmd_fmt = fmt_integer;
    {nwords, gap, ptr_init} = 21'h000000;
    {mismatches, n_compared} = '0;
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rd(5'h00, v);
    chk(v, 64'h0);
    // Post-increment memory compare, integer
    u_host.mem[8] = 32'h0000_0005;
    u_host.mem[9] = 32'h0000_0007;
    ptr_init <= 16'h0100;
    gap <= 2'h0;
    xfer(cmp_mem_postinc_op, fmt_integer, 1'b0, 3'h2, 5'h05, 5'h16);
    chk_flags(1'b1, 1'b0);
    chk(ptr, 16'h0140);
    rd(5'h05, v);
    chk(v, 64'h5);
    rd(5'h16, v);
    chk(v, 64'h7);
    // Register compares, reverse order and equal operands
    regcmp(5'h16, 5'h05, 1'b0, 1'b0);
    regcmp(5'h05, 5'h05, 1'b0, 1'b1);
    // Pre-decrement double compare with a slow host, low word first
    u_host.mem[15] = 32'h0000_0001;
    u_host.mem[14] = 32'h4000_0000;
    u_host.mem[13] = 32'h0000_0002;
    u_host.mem[12] = 32'h4008_0000;
    ptr_init <= 16'h0200;
    gap <= 2'h2;
    xfer(cmp_mem_predec_op, fmt_double, 1'b1, 3'h4, 5'h02, 5'h13);
    chk_flags(1'b1, 1'b0);
    chk(ptr, 16'h0180);
    rd(5'h13, v);
    chk(v, 64'h4008_0000_0000_0002);
    rd(5'h02, v);
    chk(v, 64'h4000_0000_0000_0001);
    // Host-register compares, single: opposite signs, then signed zeros
    hload(5'h04, 5'h14, 32'h3F80_0000, 32'hBF80_0000, fmt_single);
    chk_flags(1'b0, 1'b0);
    hload(5'h04, 5'h14, 32'h8000_0000, 32'h0, fmt_single);
    chk_flags(1'b0, 1'b1);
    // Back-to-back clears, one per format
    issue(register_zero_op, fmt_integer, 5'h05, 5'h00);
    issue(register_zero_op, fmt_single, 5'h16, 5'h00);
    issue(register_zero_op, fmt_double, 5'h13, 5'h00);
    wait_done(c);
    chk_flags(1'b0, 1'b1);
    foreach (cmd_src1[i]) if (i < 3) begin
      rd(i == 0 ? 5'h05 : i == 1 ? 5'h16 : 5'h13, v);
      chk(v, 64'h0);
    end
    // Stalled clock enable refuses commands
    clk_en <= 1'b0;
    @(negedge sys_clk);
    chk(cmd_ready, 1'b0);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    // Reverse clips: Y plane, Z plane negative side, zero divisor
    do_clip(reverse_clip_y_op, 1, '{20, 150, 8, 100}, '{10, 50, 4, 100});
    do_clip(reverse_clip_z_op, 2, '{-40, 30, -120, 100}, '{60, -10, -20, 100});
    do_clip(reverse_clip_y_op, 1, '{1, 10, 2, 100}, '{3, 10, 4, 100});
    results();
  end
endmodule // fpu_clip_clear_compare_tb
`default_nettype wire
